// ### common/hio_pkg.sv
// constants, types and state layout of the host interface select and io block
// Overview of operation
// - status led outputs red, green, blue are active low
// - led patterns per idle, connecting, connected; lit colour flashes on data activity while connecting or connected
// - first button low at startup restores default uart serial settings
// - pressing the second button requests opening a connection to a peripheral
// - both buttons low at startup enter bootloader mode
// - both buttons held low ten seconds leave bootloader and restore factory defaults
// - dsr input enters command mode, disconnects or toggles connectable, per configuration
// - with hardware flow control off, cts and rts act as general purpose pins
// - uart and spi host interfaces are never active together
// - after boot watch both interfaces, select the first one showing activity
// - uart transmit stays usable for the startup message before selection
// - during spi detection the data ready output toggles periodically
// - eight rising serial clock edges with chip select low during detection select spi and disable uart
// - a uart command during detection selects uart, stops toggling, disables spi
// - explicit interface enable or disable commands override detection
// - uart frame is 8 data bits, optional even parity, 1 stop; default no parity
// - baud generator programmable, clamped to at most 3 Mbaud
// - spi runs only as slave, clock and select come from the master
// - data ready output enabled after reset, software may disable it
// - receive blocked output signals no room; disabled after reset
// - rts output and cts input are active low
package hio_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned STARTUP_WIN_MS   = 50;
  localparam int unsigned STARTUP_WIN_CYC  = STARTUP_WIN_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_MS      = 5;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * CYC_PER_MS;
  localparam int unsigned FACTORY_HOLD_S   = 10;
  localparam int unsigned FACTORY_HOLD_CYC = FACTORY_HOLD_S * CLK_HZ;
  localparam int unsigned DRDY_HALF_MS     = 1;
  localparam int unsigned DRDY_HALF_CYC    = DRDY_HALF_MS * CYC_PER_MS;
  localparam int unsigned FLASH_MS         = 50;
  localparam int unsigned FLASH_CYC        = FLASH_MS * CYC_PER_MS;
  localparam int unsigned CNT_W            = 32;

  //////////////////////////////////////////////////////////////////////////////
  // link figures
  localparam int unsigned SPI_DETECT_EDGES = 8;
  localparam int unsigned EDGE_W           = 4;
  localparam int unsigned UART_DATA_BITS   = 8;
  localparam int unsigned UART_STOP_BITS   = 1;
  localparam int unsigned UART_MAX_BAUD    = 3_000_000;
  localparam int unsigned UART_DFLT_BAUD   = 115_200;
  localparam int unsigned BAUD_W           = 16;
  localparam int unsigned BAUD_DIV_MIN     = (CLK_HZ + UART_MAX_BAUD - 1) / UART_MAX_BAUD;
  localparam int unsigned BAUD_DIV_DFLT    = CLK_HZ / UART_DFLT_BAUD;

  //////////////////////////////////////////////////////////////////////////////
  // led codes as {green, blue, red}, low lights
  localparam logic [2:0] LED_DATA_IDLE  = 3'h3;
  localparam logic [2:0] LED_CMD_IDLE   = 3'h2;
  localparam logic [2:0] LED_CONNECTING = 3'h4;
  localparam logic [2:0] LED_CONNECTED  = 3'h5;
  localparam logic [2:0] LED_OFF        = 3'h7;

  // synchroniser lanes and button lanes
  localparam int unsigned SYNC_SCLK = 0;
  localparam int unsigned SYNC_CS   = 1;
  localparam int unsigned SYNC_DSR  = 2;
  localparam int unsigned SYNC_CTS  = 3;
  localparam int unsigned SYNC_W    = 4;
  localparam int unsigned BTN_SW1   = 0;
  localparam int unsigned BTN_SW2   = 1;
  localparam int unsigned BTN_W     = 2;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    SEL_BOOT   = 2'h0,
    SEL_DETECT = 2'h1,
    SEL_UART   = 2'h3,
    SEL_SPI    = 2'h2
  } hio_sel_t;

  typedef enum logic [1:0] {
    LINK_IDLE       = 2'h0,
    LINK_CONNECTING = 2'h1,
    LINK_CONNECTED  = 2'h2
  } hio_link_t;

  typedef enum logic [1:0] {
    DSR_OFF         = 2'h0,
    DSR_CMD_MODE    = 2'h1,
    DSR_DISCONNECT  = 2'h2,
    DSR_TOGGLE_CONN = 2'h3
  } hio_dsr_mode_t;

  typedef struct packed {
    logic              parity_en;
    logic              hw_flow_en;
    hio_dsr_mode_t     dsr_mode;
    logic              drdy_en;
    logic              norx_en;
    logic [BAUD_W-1:0] baud_div;
  } hio_cfg_t;

  localparam hio_cfg_t CFG_RST = '{parity_en: 1'b0, hw_flow_en: 1'b0, dsr_mode: DSR_OFF,
                                   drdy_en: 1'b1, norx_en: 1'b0,
                                   baud_div: BAUD_W'(BAUD_DIV_DFLT)};

  typedef struct packed {
    logic valid;
    logic uart;
    logic spi;
  } hio_if_cmd_t;

  typedef struct packed {
    logic cmd_mode;
    logic disconnect;
    logic toggle_conn;
  } hio_dsr_evt_t;

endpackage : hio_pkg

// ### hw/hio_debounce.sv
// two-flop synchroniser and stable-time debouncer for the button pins
module hio_debounce
  import hio_pkg::*;
#(
  parameter int unsigned WIDTH      = BTN_W,
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] raw_n,
  output logic      [WIDTH-1:0] stable_n
);

  typedef struct packed {
    logic [WIDTH-1:0]            s1;
    logic [WIDTH-1:0]            s2;
    logic [WIDTH-1:0][CNT_W-1:0] cnt;
    logic [WIDTH-1:0]            stb;
  } hio_dbn_state_t;

  // buttons idle high through pull-ups, so released is the safe reset view
  localparam hio_dbn_state_t DBN_RST = '{s1: '1, s2: '1, cnt: '0, stb: '1};

  hio_dbn_state_t st_ff;
  hio_dbn_state_t nxt_st;

  //////////////////////////////////////////////////////////////////////////////
  // a level must differ from the output for the whole stable time to be taken
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = raw_n;
    nxt_st.s2 = st_ff.s1;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st_ff.s2[i] == st_ff.stb[i])
        nxt_st.cnt[i] = '0;
      else if (st_ff.cnt[i] == CNT_W'(STABLE_CYC - 1))
      begin
        nxt_st.cnt[i] = '0;
        nxt_st.stb[i] = st_ff.s2[i];
      end
      else
        nxt_st.cnt[i] = st_ff.cnt[i] + CNT_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      st_ff <= DBN_RST;
    else
      st_ff <= nxt_st;
  end

  assign stable_n = st_ff.stb;

endmodule // hio_debounce

// ### hw/hio_host_select.sv
// host interface detection, status leds, startup buttons and uart/spi side pins
module hio_host_select
  import hio_pkg::*;
#(
  parameter int unsigned STARTUP_CYC   = STARTUP_WIN_CYC,
  parameter int unsigned DEBOUNCE_LEN  = DEBOUNCE_CYC,
  parameter int unsigned FACTORY_CYC   = FACTORY_HOLD_CYC,
  parameter int unsigned DRDY_HALF_LEN = DRDY_HALF_CYC,
  parameter int unsigned FLASH_LEN     = FLASH_CYC
)(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         sw1_n,
  input  wire logic         sw2_n,
  input  wire logic         dsr_n,
  input  wire logic         cts_n,
  input  wire logic         spi_sclk,
  input  wire logic         spi_cs_n,
  input  wire logic         cfg_load,
  input  wire hio_cfg_t     cfg_in,
  input  wire hio_if_cmd_t  if_cmd,
  input  wire logic         uart_cmd_seen,
  input  wire logic         cmd_mode,
  input  wire hio_link_t    link_state,
  input  wire logic         data_activity,
  input  wire logic         spi_data_ready,
  input  wire logic         rx_blocked,
  input  wire logic         rts_gpio_o,
  input  wire logic         rts_gpio_oe,
  output logic              led_red_n,
  output logic              led_green_n,
  output logic              led_blue_n,
  output logic              spi_data_avail_out,
  output logic              spi_rx_blocked_out,
  output logic              uart_en,
  output logic              spi_en,
  output logic              uart_tx_en,
  output logic              uart_parity_en,
  output logic              baud_tick,
  output logic              uart_dflt_pulse,
  output logic              bootloader,
  output logic              factory_reset,
  output logic              connect_req,
  output hio_dsr_evt_t      dsr_evt,
  output logic              rts_pin_o,
  output logic              rts_pin_oe,
  output logic              uart_tx_hold,
  output logic              cts_gpio_i
);

  typedef struct packed {
    hio_sel_t          sel;
    hio_cfg_t          cfg;
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [CNT_W-1:0]  win_cnt;
    logic [CNT_W-1:0]  hold_cnt;
    logic              boot_ldr;
    logic              fact_rst;
    logic              uart_dflt;
    logic              sw2_prev;
    logic              conn_req;
    logic [EDGE_W-1:0] edge_cnt;
    logic [CNT_W-1:0]  drdy_cnt;
    logic              drdy;
    logic              norx;
    logic [CNT_W-1:0]  flash_cnt;
    logic [2:0]        led_n;
    hio_dsr_evt_t      dsr_evt;
    logic [BAUD_W-1:0] baud_cnt;
    logic              baud_tick;
    logic              rts_o;
    logic              rts_oe;
    logic              tx_hold;
    logic              cts_gpio;
    logic              uart_en;
    logic              spi_en;
    logic              uart_tx_en;
  } hio_state_t;

  // pins idle high; tx path open from reset so the startup message can leave
  localparam hio_state_t ST_RST = '{sel: SEL_BOOT, cfg: CFG_RST, s1: '1, s2: '1, s3: '1,
                                    sw2_prev: 1'b1, led_n: LED_OFF, rts_o: 1'b1,
                                    uart_tx_en: 1'b1, default: '0};

  hio_state_t       st_ff;
  hio_state_t       nxt_st;
  logic [BTN_W-1:0] btn_n;
  logic             both_low;
  logic             sclk_rise;
  logic             cs_act;
  logic             dsr_fall;
  logic [BAUD_W-1:0] div_eff;

  //////////////////////////////////////////////////////////////////////////////
  // button pins, synchronised and debounced before any decision
  hio_debounce #(
    .WIDTH      (BTN_W),
    .STABLE_CYC (DEBOUNCE_LEN)
  ) u_btn (
    .clock    (clock),
    .reset    (reset),
    .raw_n    ({sw2_n, sw1_n}),
    .stable_n (btn_n)
  );

  // edge finders read the second and third stages only
  assign both_low  = ~btn_n[BTN_SW1] & ~btn_n[BTN_SW2];
  assign sclk_rise = st_ff.s2[SYNC_SCLK] & ~st_ff.s3[SYNC_SCLK];
  assign cs_act    = ~st_ff.s2[SYNC_CS];
  assign dsr_fall  = ~st_ff.s2[SYNC_DSR] & st_ff.s3[SYNC_DSR];
  // the divisor never drops below the fastest allowed rate
  assign div_eff   = (st_ff.cfg.baud_div < BAUD_W'(BAUD_DIV_MIN)) ? BAUD_W'(BAUD_DIV_MIN)
                                                                  : st_ff.cfg.baud_div;

  //////////////////////////////////////////////////////////////////////////////
  // whole next state
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.s1        = {cts_n, dsr_n, spi_cs_n, spi_sclk};
    nxt_st.s2        = st_ff.s1;
    nxt_st.s3        = st_ff.s2;
    nxt_st.uart_dflt = 1'b0;
    nxt_st.fact_rst  = 1'b0;
    nxt_st.conn_req  = 1'b0;
    nxt_st.dsr_evt   = '0;
    nxt_st.baud_tick = 1'b0;
    nxt_st.sw2_prev  = btn_n[BTN_SW2];

    // software configuration load
    if (cfg_load)
      nxt_st.cfg = cfg_in;

    // interface selection and startup sequence
    unique case (st_ff.sel)
      SEL_BOOT:
      begin
        if (st_ff.boot_ldr)
        begin
          if (!both_low)
            nxt_st.hold_cnt = '0;
          else if (st_ff.hold_cnt == CNT_W'(FACTORY_CYC - 1))
          begin
            nxt_st.boot_ldr = 1'b0;
            nxt_st.fact_rst = 1'b1;
            nxt_st.cfg      = CFG_RST;
            nxt_st.sel      = SEL_DETECT;
          end
          else
            nxt_st.hold_cnt = st_ff.hold_cnt + CNT_W'(1);
        end
        else if (st_ff.win_cnt == CNT_W'(STARTUP_CYC - 1))
        begin
          // buttons count only here, at the close of the startup window
          if (both_low)
            nxt_st.boot_ldr = 1'b1;
          else
          begin
            nxt_st.sel = SEL_DETECT;
            if (!btn_n[BTN_SW1])
            begin
              nxt_st.uart_dflt     = 1'b1;
              nxt_st.cfg.parity_en = CFG_RST.parity_en;
              nxt_st.cfg.baud_div  = CFG_RST.baud_div;
            end
          end
        end
        else
          nxt_st.win_cnt = st_ff.win_cnt + CNT_W'(1);
      end
      SEL_DETECT:
      begin
        // a uart command wins a tie with the last clock edge
        if (uart_cmd_seen)
          nxt_st.sel = SEL_UART;
        else if (cs_act && sclk_rise)
        begin
          // edges outside chip select never reach the counter
          if (st_ff.edge_cnt == EDGE_W'(SPI_DETECT_EDGES - 1))
            nxt_st.sel = SEL_SPI;
          else
            nxt_st.edge_cnt = st_ff.edge_cnt + EDGE_W'(1);
        end
      end
      SEL_UART,
      SEL_SPI:
      begin
        nxt_st.edge_cnt = '0;
      end
    endcase

    // explicit commands override detection; both at once is refused
    if (if_cmd.valid && st_ff.sel != SEL_BOOT)
    begin
      unique case ({if_cmd.uart, if_cmd.spi})
        2'h2: nxt_st.sel = SEL_UART;
        2'h1: nxt_st.sel = SEL_SPI;
        2'h0:
        begin
          nxt_st.sel      = SEL_DETECT;
          nxt_st.edge_cnt = '0;
        end
        2'h3: nxt_st.sel = st_ff.sel;
      endcase
    end

    // one select state drives both enables, so they can never overlap
    nxt_st.uart_en    = (nxt_st.sel == SEL_UART);
    nxt_st.spi_en     = (nxt_st.sel == SEL_SPI);
    nxt_st.uart_tx_en = (nxt_st.sel != SEL_SPI);

    // data ready: periodic beacon while detecting, real flag once on spi
    if (st_ff.sel == SEL_DETECT && st_ff.cfg.drdy_en)
    begin
      if (st_ff.drdy_cnt == CNT_W'(DRDY_HALF_LEN - 1))
      begin
        nxt_st.drdy_cnt = '0;
        nxt_st.drdy     = ~st_ff.drdy;
      end
      else
        nxt_st.drdy_cnt = st_ff.drdy_cnt + CNT_W'(1);
    end
    else
    begin
      nxt_st.drdy_cnt = '0;
      nxt_st.drdy     = (st_ff.sel == SEL_SPI) && st_ff.cfg.drdy_en && spi_data_ready;
    end

    // receive blocked only when software has switched it on
    nxt_st.norx = st_ff.cfg.norx_en && (st_ff.sel == SEL_SPI) && rx_blocked;

    // status leds; a flash blanks the lit colour for a while
    if (data_activity && (link_state == LINK_CONNECTING || link_state == LINK_CONNECTED))
      nxt_st.flash_cnt = CNT_W'(FLASH_LEN);
    else if (st_ff.flash_cnt != '0)
      nxt_st.flash_cnt = st_ff.flash_cnt - CNT_W'(1);
    unique case (link_state)
      LINK_IDLE:       nxt_st.led_n = cmd_mode ? LED_CMD_IDLE : LED_DATA_IDLE;
      LINK_CONNECTING: nxt_st.led_n = LED_CONNECTING;
      LINK_CONNECTED:  nxt_st.led_n = LED_CONNECTED;
      default:         nxt_st.led_n = LED_OFF;
    endcase
    if (st_ff.flash_cnt != '0 && link_state != LINK_IDLE)
      nxt_st.led_n = LED_OFF;

    // second button asks for a connection once out of startup
    if (st_ff.sel != SEL_BOOT && st_ff.sw2_prev && !btn_n[BTN_SW2])
      nxt_st.conn_req = 1'b1;

    // dsr assertion is repurposed by configuration
    if (st_ff.sel != SEL_BOOT && dsr_fall)
    begin
      unique case (st_ff.cfg.dsr_mode)
        DSR_OFF:         nxt_st.dsr_evt = '0;
        DSR_CMD_MODE:    nxt_st.dsr_evt.cmd_mode = 1'b1;
        DSR_DISCONNECT:  nxt_st.dsr_evt.disconnect = 1'b1;
        DSR_TOGGLE_CONN: nxt_st.dsr_evt.toggle_conn = 1'b1;
      endcase
    end

    // baud divider: one enable pulse per bit time
    if (st_ff.baud_cnt >= div_eff - BAUD_W'(1))
    begin
      nxt_st.baud_cnt  = '0;
      nxt_st.baud_tick = 1'b1;
    end
    else
      nxt_st.baud_cnt = st_ff.baud_cnt + BAUD_W'(1);

    // flow control pins, or general purpose pins when flow control is off
    if (st_ff.cfg.hw_flow_en)
    begin
      nxt_st.rts_o   = rx_blocked;
      nxt_st.rts_oe  = 1'b1;
      nxt_st.tx_hold = st_ff.s2[SYNC_CTS];
    end
    else
    begin
      nxt_st.rts_o   = rts_gpio_o;
      nxt_st.rts_oe  = rts_gpio_oe;
      nxt_st.tx_hold = 1'b0;
    end
    nxt_st.cts_gpio = st_ff.s2[SYNC_CTS];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      st_ff <= ST_RST;
    else
      st_ff <= nxt_st;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign led_green_n        = st_ff.led_n[2];
  assign led_blue_n         = st_ff.led_n[1];
  assign led_red_n          = st_ff.led_n[0];
  assign spi_data_avail_out = st_ff.drdy;
  assign spi_rx_blocked_out = st_ff.norx;
  assign uart_en            = st_ff.uart_en;
  assign spi_en             = st_ff.spi_en;
  assign uart_tx_en         = st_ff.uart_tx_en;
  assign uart_parity_en     = st_ff.cfg.parity_en;
  assign baud_tick          = st_ff.baud_tick;
  assign uart_dflt_pulse    = st_ff.uart_dflt;
  assign bootloader         = st_ff.boot_ldr;
  assign factory_reset      = st_ff.fact_rst;
  assign connect_req        = st_ff.conn_req;
  assign dsr_evt            = st_ff.dsr_evt;
  assign rts_pin_o          = st_ff.rts_o;
  assign rts_pin_oe         = st_ff.rts_oe;
  assign uart_tx_hold       = st_ff.tx_hold;
  assign cts_gpio_i         = st_ff.cts_gpio;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_exclusive;
    @(posedge clock) disable iff (reset)
    !(uart_en && spi_en);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("uart and spi enabled together");

  property p_spi_detect;
    @(posedge clock) disable iff (reset)
    (st_ff.sel == SEL_DETECT && cs_act && sclk_rise && !uart_cmd_seen && !if_cmd.valid
     && st_ff.edge_cnt == EDGE_W'(SPI_DETECT_EDGES - 1)) |=> spi_en && !uart_en && !uart_tx_en;
  endproperty
  a_spi_detect: assert property (p_spi_detect) else $error("eighth edge did not select spi");

  property p_cs_ignore;
    @(posedge clock) disable iff (reset)
    (st_ff.sel == SEL_DETECT && !cs_act && !if_cmd.valid) |=> $stable(st_ff.edge_cnt);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("edge counted without chip select");

  property p_uart_detect;
    @(posedge clock) disable iff (reset)
    (st_ff.sel == SEL_DETECT && uart_cmd_seen && !if_cmd.valid)
      |=> uart_en ##1 (!spi_en && !spi_data_avail_out);
  endproperty
  a_uart_detect: assert property (p_uart_detect) else $error("uart command did not select uart");

  property p_bootldr;
    @(posedge clock) disable iff (reset)
    (st_ff.sel == SEL_BOOT && !st_ff.boot_ldr && both_low
     && st_ff.win_cnt == CNT_W'(STARTUP_CYC - 1)) |=> bootloader && !uart_en && !spi_en;
  endproperty
  a_bootldr: assert property (p_bootldr) else $error("bootloader not entered");

  property p_factory;
    @(posedge clock) disable iff (reset)
    (st_ff.boot_ldr && both_low && st_ff.hold_cnt == CNT_W'(FACTORY_CYC - 1))
      |=> factory_reset && !bootloader ##1 !factory_reset;
  endproperty
  a_factory: assert property (p_factory) else $error("factory restore missing");

  property p_norx_off;
    @(posedge clock) disable iff (reset)
    !st_ff.cfg.norx_en |=> !spi_rx_blocked_out;
  endproperty
  a_norx_off: assert property (p_norx_off) else $error("receive blocked while disabled");

  property p_led_idle;
    @(posedge clock) disable iff (reset)
    (link_state == LINK_IDLE && !cmd_mode) |=> (led_green_n == 1'b0 && led_blue_n && led_red_n);
  endproperty
  a_led_idle: assert property (p_led_idle) else $error("data idle led pattern wrong");

  property p_conn_req;
    @(posedge clock) disable iff (reset)
    (st_ff.sel != SEL_BOOT && $fell(btn_n[BTN_SW2])) |=> connect_req;
  endproperty
  a_conn_req: assert property (p_conn_req) else $error("button press gave no connect request");

  property p_drdy_toggle;
    @(posedge clock) disable iff (reset)
    (st_ff.sel == SEL_DETECT && st_ff.cfg.drdy_en && !cfg_load && !if_cmd.valid && !uart_cmd_seen
     && st_ff.drdy_cnt == CNT_W'(DRDY_HALF_LEN - 1)) |=> (spi_data_avail_out != $past(st_ff.drdy));
  endproperty
  a_drdy_toggle: assert property (p_drdy_toggle) else $error("data ready did not toggle");

endmodule // hio_host_select

// ### sim/hio_spi_master.sv
// spi master model driving serial clock and chip select toward the block
module hio_spi_master (
  output logic sclk,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // mode 3: clock idles high and stands still between frames
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
  end

  // n rising edges at 8 MHz; sel low leaves select high to test that edges are ignored
  task automatic burst(input int n, input logic sel);
    cs_n = ~sel;
    #125;
    repeat (n)
    begin
      sclk = 1'b0;
      #62.5;
      sclk = 1'b1;
      #62.5;
    end
    #125;
    cs_n = 1'b1;
  endtask
endmodule // hio_spi_master

// ### sim/tb.sv
// self-checking testbench for the host interface select block
module tb;
  import hio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic      clock, reset, sw1_n, sw2_n, ucmd, cmd_mode, rdy, sclk, cs_n;
  hio_link_t link_state;
  logic      led_r, led_g, led_b, avail, uart_en, spi_en, tx_en, dflt, boot, fac, a;
  logic      dsr, cts, load, da, par, rts, oe, hold, nrx, cr, bt;
  hio_if_cmd_t  ic;
  hio_cfg_t     cfg;
  hio_dsr_evt_t ev;
  int        err_total, n_tests, cyc;
  wire [7:0] obs = {bt, ev.cmd_mode, cr, fac, boot, dflt, spi_en, uart_en};

  // shortened counts keep the run to a few thousand cycles
  hio_host_select #(.STARTUP_CYC(200), .DEBOUNCE_LEN(20), .FACTORY_CYC(300), .DRDY_HALF_LEN(16),
    .FLASH_LEN(10)) dut (.clock(clock), .reset(reset), .sw1_n(sw1_n), .sw2_n(sw2_n), .dsr_n(dsr),
    .cts_n(cts), .spi_sclk(sclk), .spi_cs_n(cs_n), .cfg_load(load), .cfg_in(cfg), .if_cmd(ic),
    .uart_cmd_seen(ucmd), .cmd_mode(cmd_mode), .link_state(link_state), .data_activity(da),
    .spi_data_ready(rdy), .rx_blocked(rdy), .rts_gpio_o(rdy), .rts_gpio_oe(rdy), .led_red_n(led_r),
    .led_green_n(led_g), .led_blue_n(led_b), .spi_data_avail_out(avail), .spi_rx_blocked_out(nrx),
    .uart_en(uart_en), .spi_en(spi_en), .uart_tx_en(tx_en), .uart_parity_en(par), .baud_tick(bt),
    .uart_dflt_pulse(dflt), .bootloader(boot), .factory_reset(fac), .connect_req(cr), .dsr_evt(ev),
    .rts_pin_o(rts), .rts_pin_oe(oe), .uart_tx_hold(hold), .cts_gpio_i());
  hio_spi_master m (.sclk(sclk), .cs_n(cs_n));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic cmp(input logic [2:0] g, input logic [2:0] e, input string s);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bounded wait for one observed output to go high
  task automatic wt(input int b, input int n, input string s);
    int k;
    k = 0;
    while (obs[b] !== 1'b1 && k < n)
    begin
      tick(1);
      k++;
    end
    cmp(obs[b], 1'b1, s);
  endtask
  // buttons are pin levels held through reset into the startup window
  task automatic rst(input logic s1, input logic s2);
    tick(1);
    reset = 1'b1;
    sw1_n = s1;
    sw2_n = s2;
    tick(10);
    cmp({tx_en, uart_en, spi_en}, 3'h4, "tx in reset");
    reset = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_dflt_leds;
    logic [2:0] exp [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
    rst(1'b0, 1'b1);
    wt(2, 250, "dflt pulse");
    cmp(boot, 1'b0, "no boot");
    sw1_n = 1'b1;
    tick(3);
    a = avail;
    tick(16);
    cmp(avail, {2'b00, ~a}, "beacon");
    for (int i = 0; i < 4; i++)
    begin
      cmd_mode = (i == 1);
      link_state = hio_link_t'((i < 2) ? 0 : i - 1);
      tick(2);
      cmp({led_g, led_b, led_r}, exp[i], "leds");
    end
    $display("test dflt_leds done");
  endtask

  task automatic t_spi;
    m.burst(8, 1'b0);
    tick(5);
    cmp(spi_en, 1'b0, "cs high edges");
    m.burst(7, 1'b1);
    tick(5);
    cmp(spi_en, 1'b0, "seven edges");
    m.burst(1, 1'b1);
    wt(1, 20, "spi sel");
    cmp({tx_en, uart_en}, 3'h0, "uart off");
    rdy = 1'b1;
    tick(3);
    cmp(avail, 1'b1, "drdy level");
    rdy = 1'b0;
    $display("test spi done");
  endtask

  task automatic t_uart;
    rst(1'b1, 1'b1);
    tick(220);
    ucmd = 1'b1;
    tick(1);
    ucmd = 1'b0;
    wt(0, 3, "uart sel");
    tick(40);
    cmp(avail, 1'b0, "beacon stopped");
    m.burst(64, 1'b1);
    tick(5);
    cmp({spi_en, uart_en}, 3'h1, "spi stays off");
    $display("test uart done");
  endtask

  task automatic t_boot;
    rst(1'b0, 1'b0);
    wt(3, 250, "bootloader");
    wt(4, 320, "factory");
    tick(1);
    cmp({fac, boot}, 3'h0, "boot left");
    $display("test boot done");
  endtask

  // flash, side pins, config load, dsr, forced selection, button 2 and baud rate
  task automatic t_misc;
    da = 1'b1;
    tick(1);
    da = 1'b0;
    tick(1);
    cmp({led_g, led_b, led_r}, 3'h7, "flash off");
    tick(12);
    cmp({led_g, led_b, led_r}, 3'h5, "flash end");
    rdy = 1'b1;
    tick(2);
    cmp({rts, oe, hold}, 3'h6, "gpio rts");
    rdy = 1'b0;
    cfg = '{parity_en: 1'b1, hw_flow_en: 1'b1, dsr_mode: DSR_CMD_MODE, drdy_en: 1'b1,
            norx_en: 1'b1, baud_div: CFG_RST.baud_div};
    load = 1'b1;
    tick(1);
    load = 1'b0;
    tick(3);
    cmp({par, oe, hold}, 3'h7, "flow on");
    cts = 1'b0;
    dsr = 1'b0;
    wt(6, 5, "dsr cmd");
    tick(2);
    cmp({rts, hold}, 3'h0, "cts low");
    dsr = 1'b1;
    ic = 3'h6;
    tick(1);
    cmp({tx_en, uart_en, spi_en}, 3'h6, "force uart");
    ic = 3'h5;
    tick(1);
    ic = 3'h7;
    rdy = 1'b1;
    tick(2);
    cmp({tx_en, uart_en, spi_en}, 3'h1, "force spi");
    cmp({nrx, avail}, 3'h3, "spi flags");
    ic = 3'h4;
    rdy = 1'b0;
    tick(1);
    cmp({tx_en, uart_en, spi_en}, 3'h4, "restart detect");
    ic = '0;
    sw2_n = 1'b1;
    tick(30);
    sw2_n = 1'b0;
    wt(5, 30, "connect");
    wt(7, 900, "baud tick");
    tick(BAUD_DIV_DFLT);
    cmp(obs[7], 1'b1, "baud period");
    $display("test misc done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {reset, sw1_n, sw2_n, ucmd, cmd_mode, rdy} = 6'h38;
    link_state = LINK_IDLE;
    {dsr, cts, load, da} = 4'hC;
    ic = '0;
    cfg = CFG_RST;
    t_dflt_leds;
    t_spi;
    t_uart;
    t_boot;
    t_misc;
    end_sim;
  end
endmodule // tb
